// File: logic/pad_cell_pkg.sv
// Purpose: Shared constants, field layouts and types of the pad I/O cell.
// Assumes: One core clock; pad, edge clock and slow clock are sampled inputs.
// Notes: Register map is two words on a plain strobe port.
package pad_cell_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

	// ************************************************
	// Timing and widths
	// ************************************************
	localparam int FIX_LAG_CYC = 2;
	localparam int TAP_W = 5;
	localparam int LAG_DEPTH = FIX_LAG_CYC + 31;
	localparam int WORD_W = 8;
	localparam int SYNC_N = 4;

	typedef enum logic [1:0] {
		GB_BY7,
		GB_BY8,
		GB_DUAL4
	} gb_mode_t;

	// Control word as stored at CTRL_OFS, high bits first
	typedef struct packed {
		logic gb_hold;
		logic set_val;
		gb_mode_t gb_mode;
		logic ddr_mode;
		logic dyn_lag_en;
		logic fix_lag_en;
		logic bypass;
	} cell_cfg_t;

	// Status word as read at STATUS_OFS, high bits first
	typedef struct packed {
		logic [3:0] slip_count;
		logic [WORD_W-1:0] word;
	} cell_stat_t;

	// Core-side captured input pair
	typedef struct packed {
		logic rise;
		logic fall;
	} ddr_pair_t;

endpackage : pad_cell_pkg

// File: logic/in_gearbox.sv
// Purpose: Three-stage input gearbox, serial bits in, parallel word out.
// Assumes: Edge and slow-clock strobes come from the cell on the same clock.
// Notes: Bit counting and slip live in the cell's clock control block.
`timescale 1ns/10ps
module in_gearbox
	import pad_cell_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic gb_clr,
	// Strobes from the clock control block
	input wire logic fast_edge,
	input wire logic stage2_update,
	input wire pad_cell_pkg::gb_mode_t stage2_select,
	input wire logic slow_rise,
	// Serial lanes after the delay element
	input wire logic ser_a,
	input wire logic ser_b,
	// Parallel word to the core
	output logic [pad_cell_pkg::WORD_W-1:0] word_out
);
	import pad_cell_pkg::*;

	logic [WORD_W-1:0] shift_a_reg;
	logic [3:0] shift_b_reg;
	logic [WORD_W-1:0] align_reg;
	logic [WORD_W-1:0] align_next;

	// ************************************************
	// Stage one: a bit on every fast clock edge
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shift_a_reg <= '0;
			shift_b_reg <= '0;
		end
		else if (gb_clr)
		begin
			shift_a_reg <= '0;
			shift_b_reg <= '0;
		end
		else if (fast_edge)
		begin
			shift_a_reg <= {shift_a_reg[WORD_W-2:0], ser_a};
			shift_b_reg <= {shift_b_reg[2:0], ser_b};
		end
	end

	// ************************************************
	// Stage two: word boundary and packing
	// ************************************************
	always_comb
	begin
		unique case (stage2_select)
			GB_BY7: align_next = {1'b0, shift_a_reg[6:0]};
			GB_BY8: align_next = shift_a_reg;
			GB_DUAL4: align_next = {shift_a_reg[3:0], shift_b_reg};
			default: align_next = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			align_reg <= '0;
		else if (gb_clr)
			align_reg <= '0;
		else if (stage2_update)
			align_reg <= align_next;
	end

	// ************************************************
	// Stage three: hand over on the slow clock
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			word_out <= '0;
		else if (gb_clr)
			word_out <= '0;
		else if (slow_rise)
			word_out <= align_reg;
	end

endmodule : in_gearbox

// File: logic/pad_io_cell.sv
// Purpose: One pad I/O cell: input, output and tri-state blocks with gearbox.
// Assumes: Pads, edge clock and slow clock are asynchronous; core is on sys_clk.
// Notes: Pad clocks are recovered by oversampling, so they must stay well
//        below a quarter of sys_clk.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
module pad_io_cell
	import pad_cell_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [pad_cell_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Pad side
	input wire logic pad_in,
	input wire logic pad_in_b,
	output logic pad_out,
	output logic pad_oe,
	output logic tristate_to_buffer,
	// Clocks arriving on pins
	input wire logic edge_fast_clock,
	input wire logic slow_sys_clock,
	// Core side controls
	input wire logic clk_enable,
	input wire logic local_sr,
	input wire logic [pad_cell_pkg::TAP_W-1:0] dyn_lag_tap,
	input wire logic word_slip_req,
	// Core side data
	input wire logic out_data_first,
	input wire logic out_data_second,
	input wire logic tristate_ctrl_from_core,
	output logic bypass_comb_in,
	output logic bypass_clk_in,
	output logic ddr_rise_out,
	output logic ddr_fall_out,
	output logic [pad_cell_pkg::WORD_W-1:0] gb_word_out
);
	import pad_cell_pkg::*;

	// ************************************************
	// Declarations
	// ************************************************
	cell_cfg_t cfg_reg;
	cell_stat_t stat;
	logic [SYNC_N-1:0] sync1_reg;
	logic [SYNC_N-1:0] sync2_reg;
	logic fast_prev_reg;
	logic slow_prev_reg;
	logic pad_s;
	logic pad_b_s;
	logic fast_s;
	logic slow_s;
	logic fast_edge;
	logic slow_rise;
	logic slow_fall;
	logic [LAG_DEPTH-1:0] lag_a_reg;
	logic [LAG_DEPTH-1:0] lag_b_reg;
	logic [LAG_DEPTH:0] lag_a_tap;
	logic [LAG_DEPTH:0] lag_b_tap;
	logic [5:0] lag_total;
	logic din_a;
	logic din_b;
	ddr_pair_t cap_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] word_len;
	logic slip_prev_reg;
	logic slip_pend_reg;
	logic [3:0] slip_count_reg;
	logic update_reg;
	logic gb_clr;
	logic [WORD_W-1:0] gb_word;

	// ************************************************
	// Pin synchronisers
	// ************************************************
	// Everything from a pin passes two flops; only stage two is read
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {slow_sys_clock, edge_fast_clock, pad_in_b, pad_in};
			sync2_reg <= sync1_reg;
		end
	end

	assign pad_s = sync2_reg[0];
	assign pad_b_s = sync2_reg[1];
	assign fast_s = sync2_reg[2];
	assign slow_s = sync2_reg[3];

	// ************************************************
	// Clock edge recovery
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fast_prev_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
		end
		else
		begin
			fast_prev_reg <= fast_s;
			slow_prev_reg <= slow_s;
		end
	end

	// Both edges of the fast clock carry a bit
	assign fast_edge = fast_s ^ fast_prev_reg;
	assign slow_rise = slow_s & ~slow_prev_reg;
	assign slow_fall = ~slow_s & slow_prev_reg;

	// ************************************************
	// Register port
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			cfg_reg <= cell_cfg_t'(CTRL_RESET[7:0]);
		else if (reg_wr && reg_addr == CTRL_OFS)
			cfg_reg <= cell_cfg_t'(reg_wdata[7:0]);
	end

	assign stat.slip_count = slip_count_reg;
	assign stat.word = gb_word;

	// Read data stands for exactly one cycle; unmapped reads give zero
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd && reg_addr == CTRL_OFS)
			reg_rdata <= {24'h00_0000, cfg_reg};
		else if (reg_rd && reg_addr == STATUS_OFS)
			reg_rdata <= {20'h0_0000, stat};
		else
			reg_rdata <= '0;
	end

	// ************************************************
	// Delay element
	// ************************************************
	// A shift line of core cycles; coarse, but glitch free on tap changes
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lag_a_reg <= '0;
			lag_b_reg <= '0;
		end
		else
		begin
			lag_a_reg <= {lag_a_reg[LAG_DEPTH-2:0], pad_s};
			lag_b_reg <= {lag_b_reg[LAG_DEPTH-2:0], pad_b_s};
		end
	end

	assign lag_a_tap = {lag_a_reg, pad_s};
	assign lag_b_tap = {lag_b_reg, pad_b_s};

	always_comb
	begin
		lag_total = 6'h00;
		if (cfg_reg.fix_lag_en)
			lag_total = lag_total + 6'(FIX_LAG_CYC);
		if (cfg_reg.dyn_lag_en)
			lag_total = lag_total + {1'b0, dyn_lag_tap};
	end

	assign din_a = lag_a_tap[lag_total];
	assign din_b = lag_b_tap[lag_total];

	// ************************************************
	// Bypass path
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bypass_comb_in <= 1'b0;
			bypass_clk_in <= 1'b0;
		end
		else
		begin
			// Undelayed pad, no capture register in the way
			bypass_comb_in <= cfg_reg.bypass & pad_s;
			bypass_clk_in <= cfg_reg.bypass & pad_s;
		end
	end

	// ************************************************
	// Input register block
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			cap_reg <= '0;
		else if (local_sr)
			cap_reg <= {2{cfg_reg.set_val}};
		else if (clk_enable)
		begin
			if (slow_rise && cfg_reg.ddr_mode)
				cap_reg.rise <= din_a;
			else if (slow_rise)
				cap_reg.fall <= din_a;
			if (slow_fall && cfg_reg.ddr_mode)
				cap_reg.fall <= din_a;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ddr_rise_out <= 1'b0;
			ddr_fall_out <= 1'b0;
		end
		else
		begin
			ddr_rise_out <= cap_reg.rise;
			ddr_fall_out <= cap_reg.fall;
		end
	end

	// ************************************************
	// Output register block
	// ************************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pad_out <= 1'b0;
		else if (local_sr)
			pad_out <= cfg_reg.set_val;
		else if (clk_enable && slow_rise)
			pad_out <= out_data_first;
		else if (clk_enable && slow_fall && cfg_reg.ddr_mode)
			pad_out <= out_data_second;
	end

	// ************************************************
	// Tri-state register block
	// ************************************************
	// High on tristate_to_buffer turns the driver off
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tristate_to_buffer <= 1'b1;
			pad_oe <= 1'b0;
		end
		else if (local_sr)
		begin
			tristate_to_buffer <= cfg_reg.set_val;
			pad_oe <= ~cfg_reg.set_val;
		end
		else if (clk_enable && slow_rise)
		begin
			tristate_to_buffer <= tristate_ctrl_from_core;
			pad_oe <= ~tristate_ctrl_from_core;
		end
	end

	// ************************************************
	// Gearbox clock control
	// ************************************************
	assign gb_clr = cfg_reg.gb_hold;

	always_comb
	begin
		unique case (cfg_reg.gb_mode)
			GB_BY7: word_len = 4'h7;
			GB_BY8: word_len = 4'h8;
			GB_DUAL4: word_len = 4'h4;
			default: word_len = 4'h8;
		endcase
	end

	// Slip request is taken on its rising edge only
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			slip_prev_reg <= 1'b0;
		else
			slip_prev_reg <= word_slip_req;
	end

	// A new request wins over the bit that consumes the pending one
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			slip_pend_reg <= 1'b0;
		else if (gb_clr)
			slip_pend_reg <= 1'b0;
		else if (word_slip_req && !slip_prev_reg)
			slip_pend_reg <= 1'b1;
		else if (fast_edge)
			slip_pend_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			slip_count_reg <= '0;
		else if (gb_clr)
			slip_count_reg <= '0;
		else if (word_slip_req && !slip_prev_reg)
			slip_count_reg <= slip_count_reg + 4'h1;
	end

	// Skipping one count moves the boundary by exactly one bit
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bit_cnt_reg <= '0;
			update_reg <= 1'b0;
		end
		else if (gb_clr)
		begin
			bit_cnt_reg <= '0;
			update_reg <= 1'b0;
		end
		else
		begin
			update_reg <= 1'b0;
			if (fast_edge && !slip_pend_reg)
			begin
				if (bit_cnt_reg == word_len - 4'h1)
				begin
					bit_cnt_reg <= '0;
					update_reg <= 1'b1;
				end
				else
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			else if (fast_edge)
				bit_cnt_reg <= bit_cnt_reg;
		end
	end

	// ************************************************
	// Gearbox
	// ************************************************
	in_gearbox u_gearbox (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.gb_clr(gb_clr),
		.fast_edge(fast_edge),
		.stage2_update(update_reg),
		.stage2_select(cfg_reg.gb_mode),
		.slow_rise(slow_rise),
		.ser_a(din_a),
		.ser_b(din_b),
		.word_out(gb_word)
	);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			gb_word_out <= '0;
		else
			gb_word_out <= gb_word;
	end

endmodule : pad_io_cell

// File: verif/pad_cell_assertions.sv
// Purpose: Port-level checks of the pad I/O cell.
// Assumes: Control word is mirrored from register writes.
// Notes: Checker sees ports only, so internal timing is bounded loosely.
`timescale 1ns/10ps
module pad_cell_assertions
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [pad_cell_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Pad and core
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic tristate_to_buffer,
	input wire logic clk_enable,
	input wire logic local_sr,
	input wire logic bypass_comb_in,
	input wire logic bypass_clk_in,
	input wire logic ddr_fall_out,
	input wire logic [pad_cell_pkg::WORD_W-1:0] gb_word_out
);
	import pad_cell_pkg::*;
	cell_cfg_t cfg_reg;
	// ****
	// Control mirror, needed as no internals are visible
	// ****
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			cfg_reg <= cell_cfg_t'(CTRL_RESET[7:0]);
		else if (reg_wr && reg_addr == CTRL_OFS)
			cfg_reg <= cell_cfg_t'(reg_wdata[7:0]);
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	sequence sr_held;
		local_sr [*3];
	endsequence
	sequence hold_held;
		cfg_reg.gb_hold [*3];
	endsequence
	a_oe_inverse: assert property (pad_oe == !tristate_to_buffer)
		else $error("Pad enable is not the inverse of tristate");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("Read data not zero outside read answer");
	a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) != CTRL_OFS
		&& $past(reg_addr) != STATUS_OFS |-> reg_rdata == 32'h0)
		else $error("Unmapped read returned data");
	a_ctrl_readback: assert property ($past(reg_rd) && $past(reg_addr) == CTRL_OFS
		|-> reg_rdata == {24'h0, $past(cfg_reg)})
		else $error("Control readback differs from last write");
	a_bypass_off: assert property ((!cfg_reg.bypass) [*3] |-> !bypass_comb_in && !bypass_clk_in)
		else $error("Bypass outputs active while bypass is off");
	a_hold_clears: assert property (hold_held |-> gb_word_out == 8'h00)
		else $error("Gearbox word not clear while held");
	a_by7_width: assert property ($changed(gb_word_out) && cfg_reg.gb_mode == GB_BY7 |-> !gb_word_out[7])
		else $error("Seven-bit word uses bit seven");
	a_ce_freeze: assert property ($past(!clk_enable && !local_sr)
		|-> $stable(pad_out) && $stable(tristate_to_buffer))
		else $error("Register moved with clock enable low");
	a_sr_forces: assert property (sr_held |-> pad_out == cfg_reg.set_val
		&& tristate_to_buffer == cfg_reg.set_val)
		else $error("Local set/reset did not force set value");
endmodule : pad_cell_assertions

bind pad_io_cell pad_cell_assertions pad_cell_assertions_i (.sys_clk(sys_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pad_out(pad_out), .pad_oe(pad_oe),
	.tristate_to_buffer(tristate_to_buffer), .clk_enable(clk_enable), .local_sr(local_sr),
	.bypass_comb_in(bypass_comb_in), .bypass_clk_in(bypass_clk_in),
	.ddr_fall_out(ddr_fall_out), .gb_word_out(gb_word_out));

// File: verif/serial_source.sv
// Purpose: Source-synchronous serial transmitter on the pad side.
// Assumes: Each fast clock edge carries one bit, data centred on edges.
// Notes: Clocks stand still between frames; idle lanes show the inverse bit.
`timescale 1ns/10ps
module serial_source
(
	// Serial lanes
	output logic lane_a,
	output logic lane_b,
	// Source clocks
	output logic fast_clk,
	output logic slow_clk
);
	initial
	begin
		lane_a = 1'b0;
		lane_b = 1'b0;
		fast_clk = 1'b0;
		slow_clk = 1'b0;
	end
	// Oldest bit first, one bit per fast edge, then one slow clock pulse
	task automatic send(input logic [15:0] a, input logic [15:0] b, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			lane_a = a[i];
			lane_b = b[i];
			#16;
			fast_clk = !fast_clk;
			#16;
		end
		lane_b = !lane_b;
		slow(1'b1, !lane_a);
		slow(1'b0, lane_a);
	endtask : send
	// Moves the slow clock with lane A set up half a bit ahead
	task automatic slow(input logic lvl, input logic a);
		lane_a = a;
		#16;
		slow_clk = lvl;
		#16;
	endtask : slow
endmodule : serial_source

// File: verif/tb_top.sv
// Purpose: Self-checking bench of the pad I/O cell.
// Assumes: Register port strobes one cycle, read data the cycle after.
// Notes: Waits after pad edges cover sync and edge detect latency.
`timescale 1ns/10ps
module tb_top;
	import pad_cell_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic clk_enable = 1'b1;
	logic local_sr = 1'b0;
	logic [TAP_W-1:0] dyn_lag_tap = 5'h00;
	logic word_slip_req = 1'b0;
	logic out_data_first = 1'b0;
	logic out_data_second = 1'b0;
	logic tristate_ctrl_from_core = 1'b1;
	logic [31:0] reg_rdata;
	logic pad_in, pad_in_b, pad_out, pad_oe, tristate_to_buffer, fclk, sclk;
	logic bypass_comb_in, bypass_clk_in, ddr_rise_out, ddr_fall_out;
	logic [WORD_W-1:0] gb_word_out;
	int err_total = 0;
	int n_checks = 0;
	always #2 sys_clk = !sys_clk;
	pad_io_cell pad_io_cell_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pad_in(pad_in), .pad_in_b(pad_in_b), .pad_out(pad_out), .pad_oe(pad_oe),
		.tristate_to_buffer(tristate_to_buffer), .edge_fast_clock(fclk),
		.slow_sys_clock(sclk), .clk_enable(clk_enable), .local_sr(local_sr),
		.dyn_lag_tap(dyn_lag_tap), .word_slip_req(word_slip_req),
		.out_data_first(out_data_first), .out_data_second(out_data_second),
		.tristate_ctrl_from_core(tristate_ctrl_from_core), .bypass_comb_in(bypass_comb_in),
		.bypass_clk_in(bypass_clk_in), .ddr_rise_out(ddr_rise_out),
		.ddr_fall_out(ddr_fall_out), .gb_word_out(gb_word_out));
	serial_source serial_source_i (.lane_a(pad_in), .lane_b(pad_in_b), .fast_clk(fclk),
		.slow_clk(sclk));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
	task automatic settle;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle
	// Clears the gearbox, then runs one frame and checks word and status
	task automatic gb_case(input string nm, input logic [7:0] c, input logic [15:0] a,
		input logic [15:0] b, input int n, input logic slip, input logic [7:0] exp);
		logic [31:0] d;
		wr(CTRL_OFS, 32'h80);
		wr(CTRL_OFS, {24'h0, c});
		@(negedge sys_clk);
		chk({nm, " cleared"}, 32'h0, {24'h0, gb_word_out});
		if (slip)
		begin
			@(posedge sys_clk);
			word_slip_req <= 1'b1;
			@(posedge sys_clk);
			word_slip_req <= 1'b0;
			settle();
		end
		serial_source_i.send(a, b, n);
		settle();
		chk({nm, " word"}, {24'h0, exp}, {24'h0, gb_word_out});
		rd(STATUS_OFS, d);
		chk({nm, " status"}, {20'h0, 3'h0, slip, exp}, d);
		$display("test %s done", nm);
	endtask : gb_case
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		logic [31:0] d;
		chk("reset tristate", 32'h1, {31'h0, tristate_to_buffer});
		rd(CTRL_OFS, d);
		chk("ctrl reset", CTRL_RESET, d);
		wr(4'h8, 32'hff);
		rd(4'h8, d);
		chk("unmapped read", 32'h0, d);
		rd(CTRL_OFS, d);
		chk("ctrl after unmapped", CTRL_RESET, d);
		$display("test regs done");
	endtask : t_regs
	task automatic t_gear;
		@(posedge sys_clk);
		dyn_lag_tap <= 5'h04;
		// Six cycles of lag move every sample back one bit; neither delay alone does
		gb_case("by8 lag", 8'h16, 16'h00a5, 16'h0, 8, 1'b0, 8'h52);
		gb_case("by7", 8'h00, 16'h005b, 16'h0, 7, 1'b0, 8'h5b);
		gb_case("dual4", 8'h20, 16'h000c, 16'h0003, 4, 1'b0, 8'hc3);
		gb_case("slip", 8'h10, 16'h015a, 16'h0, 9, 1'b1, 8'h5a);
	endtask : t_gear
	task automatic t_capture;
		wr(CTRL_OFS, 32'h80);
		out_data_first <= 1'b1;
		tristate_ctrl_from_core <= 1'b0;
		serial_source_i.slow(1'b1, 1'b1);
		settle();
		chk("sdr fall", 32'h1, {31'h0, ddr_fall_out});
		chk("sdr pad out", 32'h1, {31'h0, pad_out});
		chk("tristate on", 32'h0, {31'h0, tristate_to_buffer});
		serial_source_i.slow(1'b0, 1'b0);
		settle();
		chk("sdr no fall capture", 32'h1, {31'h0, ddr_fall_out});
		wr(CTRL_OFS, 32'h88);
		tristate_ctrl_from_core <= 1'b1;
		serial_source_i.slow(1'b1, 1'b1);
		settle();
		chk("ddr rise", 32'h1, {31'h0, ddr_rise_out});
		chk("ddr pad first", 32'h1, {31'h0, pad_out});
		serial_source_i.slow(1'b0, 1'b0);
		settle();
		chk("ddr fall", 32'h0, {31'h0, ddr_fall_out});
		chk("ddr pad second", 32'h0, {31'h0, pad_out});
		chk("tristate off", 32'h1, {31'h0, tristate_to_buffer});
		wr(CTRL_OFS, 32'h81);
		serial_source_i.slow(1'b1, 1'b1);
		settle();
		chk("bypass", 32'h3, {30'h0, bypass_comb_in, bypass_clk_in});
		serial_source_i.slow(1'b0, 1'b0);
		$display("test capture done");
	endtask : t_capture
	task automatic t_ctrl;
		wr(CTRL_OFS, 32'hc0);
		local_sr <= 1'b1;
		settle();
		chk("set value", 32'h7, {29'h0, pad_out, tristate_to_buffer, ddr_fall_out});
		@(posedge sys_clk);
		local_sr <= 1'b0;
		clk_enable <= 1'b0;
		out_data_first <= 1'b0;
		serial_source_i.slow(1'b1, 1'b0);
		settle();
		chk("enable low hold", 32'h1, {31'h0, pad_out});
		@(posedge sys_clk);
		clk_enable <= 1'b1;
		serial_source_i.slow(1'b0, 1'b0);
		$display("test ctrl done");
	endtask : t_ctrl
	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	initial
	begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(negedge sys_clk);
		t_regs();
		t_gear();
		t_capture();
		t_ctrl();
		results();
	end
	// Watchdog: the run needs a few microseconds
	initial
	begin
		#100000;
		err_total++;
		results();
	end
endmodule : tb_top
